// *** src/pps_pkg.sv ***
// Package: widths, register map, field positions and waveform carrier for the power and sum-rms block
package pps_pkg;

  // ==================== Widths ====================
  localparam int WAVE_W    = 28;              // Compensated waveform sample width
  localparam int SUM_W     = WAVE_W + 2;      // Current sum of four channels
  localparam int PROD_W    = 2 * WAVE_W;      // Current times voltage product
  localparam int SQ_W      = 2 * SUM_W;       // Square of the current sum
  localparam int REG_W     = 32;              // Register data width
  localparam int ACC_W     = 64;              // Mean square plus offset term
  localparam int ROOT_W    = 31;              // Bits resolved by the square root
  localparam int ADDR_W    = 8;

  // ==================== Scaling ====================
  localparam int GAIN_FRAC    = 27;           // Gain factor is 1 + coef / 2^27
  localparam int RMS_OS_SHIFT = 15;           // Rms offset weight 2^15 on the mean square
  localparam int PWR_SHIFT    = PROD_W - REG_W; // Product to power register scaling
  localparam int LPF_K_DEF    = 14;           // Low-pass shift, 64 dB at 100 Hz ripple
  localparam logic [REG_W-1:0] RMS_FULL_SCALE = 32'h0326_AF15; // 52,866,837
  localparam logic [REG_W-1:0] PWR_FULL_SCALE = 32'h013D_BE5E; // 20,823,646
  localparam int SAMPLE_HZ = 4000;            // Upstream sample strobe rate

  // ==================== Register offsets ====================
  localparam logic [ADDR_W-1:0] OFS_RUN        = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CONFIG_WORD_ZERO    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_REACTIVE_DISABLE    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SUM_THR    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_N_RMS_OS   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_S_RMS_OS   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PGAIN      = 8'h18; // Phases A, B, C at +0, +4, +8
  localparam logic [ADDR_W-1:0] OFS_ACT_OS     = 8'h24; // Phases A, B, C
  localparam logic [ADDR_W-1:0] OFS_REACT_OS   = 8'h30; // Phases A, B, C
  localparam logic [ADDR_W-1:0] OFS_STATUS_WORD_ZERO    = 8'h3C;
  localparam logic [ADDR_W-1:0] OFS_MASK       = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_N_RMS      = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_S_RMS      = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_ACT_PWR    = 8'h4C; // Phases A, B, C
  localparam logic [ADDR_W-1:0] OFS_REACT_PWR  = 8'h58; // Phases A, B, C
  localparam logic [ADDR_W-1:0] OFS_STEP       = 8'h04;

  // ==================== Fields ====================
  localparam int CFG_SUM_LSB   = 0;           // Two-bit sum selector
  localparam int CFG_ACT_BYP   = 2;
  localparam int CFG_REACT_BYP = 3;
  localparam int ST_MISMATCH   = 0;
  localparam logic [1:0] SUM_ADD_N = 2'h1;
  localparam logic [1:0] SUM_SUB_N = 2'h2;
  localparam logic [REG_W-1:0] REG_RESET = 32'h0000_0000;

  // ==================== Carrier ====================
  typedef struct packed {
    logic [2:0][WAVE_W-1:0] cur;    // Phase currents A, B, C
    logic [2:0][WAVE_W-1:0] quad;   // Phase currents shifted 90 degrees
    logic [2:0][WAVE_W-1:0] volt;   // Phase voltages A, B, C
    logic [WAVE_W-1:0]      neu;    // Neutral current
  } pps_wave_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ROOT = 2'b01,
    ST_POST = 2'b10
  } pps_state_type;

endpackage : pps_pkg

// *** src/pps_lowpass.sv ***
// Single-pole power low-pass with bypass, stepped by the sample strobe
`timescale 1ns/1ps
module pps_lowpass #(
  parameter int XW    = 56,
  parameter int LPF_K = 14
) (
  input  wire logic                 mclk_in,
  input  wire logic                 reset_in,
  input  wire logic                 sample_in,
  input  wire logic                 bypass_in,
  input  wire logic signed [XW-1:0] x_in,
  output logic signed [XW-1:0]      y_out
);

  localparam int AW = XW + LPF_K;

  logic signed [AW-1:0] acc_reg;
  logic signed [AW-1:0] acc_next;
  logic signed [XW-1:0] y_reg;
  logic signed [XW-1:0] y_next;
  logic signed [AW-1:0] x_ext;
  logic signed [AW-1:0] y_now;

  if (LPF_K < 1 || LPF_K > 24) begin : g_bad_k
    $error("pps_lowpass: LPF_K out of range");
  end

  // ==================== Filter update ====================
  always_comb begin
    x_ext    = AW'(x_in);
    y_now    = acc_reg >>> LPF_K;
    acc_next = acc_reg;
    y_next   = y_reg;
    if (sample_in) begin
      acc_next = acc_reg + x_ext - y_now;
      y_next   = bypass_in ? x_in : XW'(acc_next >>> LPF_K);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      acc_reg <= '0;
      y_reg   <= '0;
    end else begin
      acc_reg <= acc_next;
      y_reg   <= y_next;
    end
  end

  assign y_out = y_reg;

endmodule : pps_lowpass

// *** src/pps_meter_top.sv ***
// Neutral and current-sum rms with mismatch flag, per-phase active and reactive power
`timescale 1ns/1ps
// How it works
// - Neutral rms with its own offset term
// - Sum rms, own offset, phase rms scaling
// - Selector: 00/11 ABC, 01 plus N, 10 minus N
// - Mismatch flag on threshold comparison change
// - Active: product, optional filter, gain, offset
// - Bypass shows raw product, else filtered
// - Filter gives 64 dB harmonic attenuation
// - Active power updates every sample
// - Three identical phases, own coefficients
// - Power gain scaled like current gain
// - Gain factor one plus coef over 2^27
// - Offsets in power output units
// - Reactive: quadrature current product, same chain
// - Reactive power updates every sample, held at zero while reactive disable is set
// - Sum rms recalculated for each sample that arrives while the root is idle
module pps_meter_top #(
  parameter int LPF_K = pps_pkg::LPF_K_DEF
) (
  input  wire logic                       mclk_in,
  input  wire logic                       reset_in,
  input  wire logic [pps_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [pps_pkg::REG_W-1:0]  wdata_in,
  input  wire logic                       wr_in,
  input  wire logic                       rd_in,
  output logic [pps_pkg::REG_W-1:0]       rdata_out,
  input  wire pps_pkg::pps_wave_type      waves_in,
  input  wire logic                       sample_valid_in,
  output logic                            result_valid_out,
  output logic                            mismatch_irq_out
);
  import pps_pkg::*;

  if (LPF_K < 1 || LPF_K > 24) begin : g_bad_k
    $error("pps_meter_top: LPF_K out of range");
  end

  // ==================== Decode helper ====================
  function automatic logic [2:0] phase_hit(input logic [ADDR_W-1:0] a,
                                           input logic [ADDR_W-1:0] base);
    phase_hit = '0;
    for (int i = 0; i < 3; i++) begin
      if (a == base + ADDR_W'(4 * i)) begin
        phase_hit[i] = 1'b1;
      end
    end
  endfunction : phase_hit

  // ==================== Control registers ====================
  logic                        run_reg,       run_next;
  logic [1:0]                  sum_sel_reg,   sum_sel_next;
  logic                        act_byp_reg,   act_byp_next;
  logic                        react_byp_reg, react_byp_next;
  logic                        reactive_disable_reg,   reactive_disable_next;
  logic [REG_W-1:0]            thr_reg,       thr_next;
  logic [REG_W-1:0]            n_os_reg,      n_os_next;
  logic [REG_W-1:0]            s_os_reg,      s_os_next;
  logic [2:0][REG_W-1:0]       gain_reg,      gain_next;
  logic [2:0][REG_W-1:0]       act_os_reg,    act_os_next;
  logic [2:0][REG_W-1:0]       react_os_reg,  react_os_next;
  logic                        mask_reg,      mask_next;
  logic                        flag_reg,      flag_next;
  logic                        irq_reg,       irq_next;
  logic [REG_W-1:0]            rdata_reg,     rdata_next;
  logic                        flag_set;

  // ==================== Result registers ====================
  logic [REG_W-1:0]            n_rms_reg,     n_rms_next;
  logic [REG_W-1:0]            s_rms_reg,     s_rms_next;
  logic [5:0][REG_W-1:0]       pwr_reg,       pwr_next;
  logic                        cmp_reg,       cmp_next;
  logic                        post_reg,      post_next;
  logic                        valid_reg,     valid_next;
  pps_state_type               state_reg,     state_next;
  logic [4:0]                  bit_reg,       bit_next;
  logic [1:0][REG_W-1:0]       root_reg,      root_next;
  logic [1:0][ACC_W-1:0]       val_reg,       val_next;

  // ==================== Datapath front ====================
  logic                        step;
  logic signed [SUM_W-1:0]     isum;
  logic signed [5:0][PROD_W-1:0] prod;
  logic signed [5:0][PROD_W-1:0] filt;
  logic signed [1:0][SQ_W-1:0] sq;
  logic signed [1:0][SQ_W-1:0] msq;

  assign step = sample_valid_in & run_reg;

  always_comb begin
    isum = SUM_W'($signed(waves_in.cur[0])) + SUM_W'($signed(waves_in.cur[1]))
         + SUM_W'($signed(waves_in.cur[2]));
    if (sum_sel_reg == SUM_ADD_N) begin
      isum = isum + SUM_W'($signed(waves_in.neu));
    end else if (sum_sel_reg == SUM_SUB_N) begin
      isum = isum - SUM_W'($signed(waves_in.neu));
    end
    for (int p = 0; p < 3; p++) begin
      prod[p]     = $signed(waves_in.cur[p]) * $signed(waves_in.volt[p]);
      prod[p + 3] = $signed(waves_in.quad[p]) * $signed(waves_in.volt[p]);
    end
    sq[0] = SQ_W'($signed(waves_in.neu)) * SQ_W'($signed(waves_in.neu));
    sq[1] = isum * isum;
  end

  // Six power filters: active A..C then reactive A..C
  for (genvar k = 0; k < 6; k++) begin : g_pwr
    pps_lowpass #(
      .XW    (PROD_W),
      .LPF_K (LPF_K)
    ) u_lpf (
      .mclk_in   (mclk_in),
      .reset_in  (reset_in),
      .sample_in (step),
      .bypass_in ((k < 3) ? act_byp_reg : react_byp_reg),
      .x_in      (prod[k]),
      .y_out     (filt[k])
    );
  end

  // Mean square filters for neutral and sum rms
  for (genvar r = 0; r < 2; r++) begin : g_rms
    pps_lowpass #(
      .XW    (SQ_W),
      .LPF_K (LPF_K)
    ) u_lpf (
      .mclk_in   (mclk_in),
      .reset_in  (reset_in),
      .sample_in (step),
      .bypass_in (1'b0),
      .x_in      (sq[r]),
      .y_out     (msq[r])
    );
  end

  // ==================== Power back end and rms root ====================
  logic signed [REG_W-1:0]     pw;
  logic signed [2*REG_W-1:0]   gp;
  logic signed [ACC_W-1:0]     ms_os;
  logic [REG_W-1:0]            trial;
  logic [2*REG_W-1:0]          trial_sq;
  logic [REG_W-1:0]            os_word;

  always_comb begin
    pw         = '0;
    gp         = '0;
    ms_os      = '0;
    trial      = '0;
    trial_sq   = '0;
    os_word    = '0;
    pwr_next   = pwr_reg;
    post_next  = step;
    state_next = state_reg;
    bit_next   = bit_reg;
    root_next  = root_reg;
    val_next   = val_reg;
    n_rms_next = n_rms_reg;
    s_rms_next = s_rms_reg;
    cmp_next   = cmp_reg;
    valid_next = 1'b0;
    flag_set   = 1'b0;
    if (post_reg) begin
      for (int k = 0; k < 6; k++) begin
        pw = filt[k][PWR_SHIFT +: REG_W];
        gp = pw * $signed(gain_reg[k % 3]);
        pwr_next[k] = REG_W'(pw + gp[GAIN_FRAC +: REG_W]
                    + ((k < 3) ? act_os_reg[k % 3] : react_os_reg[k % 3]));
        if (k >= 3 && reactive_disable_reg) begin
          pwr_next[k] = '0;
        end
      end
    end
    case (state_reg)
      ST_IDLE: begin
        if (post_reg) begin
          for (int r = 0; r < 2; r++) begin
            os_word = (r == 0) ? n_os_reg : s_os_reg;
            ms_os = ACC_W'(msq[r])
                  + (ACC_W'($signed(os_word)) <<< RMS_OS_SHIFT);
            val_next[r]  = ms_os[ACC_W-1] ? '0 : ACC_W'(ms_os);
            root_next[r] = '0;
          end
          bit_next   = 5'(ROOT_W - 1);
          state_next = ST_ROOT;
        end
      end
      ST_ROOT: begin
        for (int r = 0; r < 2; r++) begin
          trial    = root_reg[r] | (REG_W'(1) << bit_reg);
          trial_sq = trial * trial;
          if (trial_sq <= val_reg[r]) begin
            root_next[r] = trial;
          end
        end
        bit_next = bit_reg - 5'h1;
        if (bit_reg == 5'h0) begin
          state_next = ST_POST;
        end
      end
      ST_POST: begin
        n_rms_next = root_reg[0];
        s_rms_next = root_reg[1];
        cmp_next   = root_reg[1] > thr_reg;
        flag_set   = cmp_next != cmp_reg;
        valid_next = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ==================== Register bus ====================
  logic [2:0] hit_gain;
  logic [2:0] hit_act;
  logic [2:0] hit_react;
  logic [2:0] hit_apwr;
  logic [2:0] hit_rpwr;

  always_comb begin
    hit_gain       = phase_hit(addr_in, OFS_PGAIN);
    hit_act        = phase_hit(addr_in, OFS_ACT_OS);
    hit_react      = phase_hit(addr_in, OFS_REACT_OS);
    hit_apwr       = phase_hit(addr_in, OFS_ACT_PWR);
    hit_rpwr       = phase_hit(addr_in, OFS_REACT_PWR);
    run_next       = run_reg;
    sum_sel_next   = sum_sel_reg;
    act_byp_next   = act_byp_reg;
    react_byp_next = react_byp_reg;
    reactive_disable_next   = reactive_disable_reg;
    thr_next       = thr_reg;
    n_os_next      = n_os_reg;
    s_os_next      = s_os_reg;
    gain_next      = gain_reg;
    act_os_next    = act_os_reg;
    react_os_next  = react_os_reg;
    mask_next      = mask_reg;
    flag_next      = flag_reg;
    rdata_next     = '0;
    if (wr_in) begin
      if (addr_in == OFS_RUN) begin
        run_next = wdata_in[0];
      end else if (addr_in == OFS_CONFIG_WORD_ZERO) begin
        sum_sel_next   = wdata_in[CFG_SUM_LSB +: 2];
        act_byp_next   = wdata_in[CFG_ACT_BYP];
        react_byp_next = wdata_in[CFG_REACT_BYP];
      end else if (addr_in == OFS_REACTIVE_DISABLE) begin
        reactive_disable_next = wdata_in[0];
      end else if (addr_in == OFS_SUM_THR) begin
        thr_next = wdata_in;
      end else if (addr_in == OFS_N_RMS_OS) begin
        n_os_next = wdata_in;
      end else if (addr_in == OFS_S_RMS_OS) begin
        s_os_next = wdata_in;
      end else if (addr_in == OFS_STATUS_WORD_ZERO) begin
        flag_next = flag_reg & ~wdata_in[ST_MISMATCH];
      end else if (addr_in == OFS_MASK) begin
        mask_next = wdata_in[ST_MISMATCH];
      end else begin
        for (int p = 0; p < 3; p++) begin
          if (hit_gain[p]) begin
            gain_next[p] = wdata_in;
          end
          if (hit_act[p]) begin
            act_os_next[p] = wdata_in;
          end
          if (hit_react[p]) begin
            react_os_next[p] = wdata_in;
          end
        end
      end
    end
    if (flag_set) begin
      flag_next = 1'b1;
    end
    irq_next = flag_next & mask_next;
    if (rd_in) begin
      if (addr_in == OFS_RUN) begin
        rdata_next = {31'h0, run_reg};
      end else if (addr_in == OFS_CONFIG_WORD_ZERO) begin
        rdata_next = {28'h0, react_byp_reg, act_byp_reg, sum_sel_reg};
      end else if (addr_in == OFS_REACTIVE_DISABLE) begin
        rdata_next = {31'h0, reactive_disable_reg};
      end else if (addr_in == OFS_SUM_THR) begin
        rdata_next = thr_reg;
      end else if (addr_in == OFS_N_RMS_OS) begin
        rdata_next = n_os_reg;
      end else if (addr_in == OFS_S_RMS_OS) begin
        rdata_next = s_os_reg;
      end else if (addr_in == OFS_STATUS_WORD_ZERO) begin
        rdata_next = {31'h0, flag_reg};
      end else if (addr_in == OFS_MASK) begin
        rdata_next = {31'h0, mask_reg};
      end else if (addr_in == OFS_N_RMS) begin
        rdata_next = n_rms_reg;
      end else if (addr_in == OFS_S_RMS) begin
        rdata_next = s_rms_reg;
      end else begin
        for (int p = 0; p < 3; p++) begin
          if (hit_gain[p]) begin
            rdata_next = gain_reg[p];
          end
          if (hit_act[p]) begin
            rdata_next = act_os_reg[p];
          end
          if (hit_react[p]) begin
            rdata_next = react_os_reg[p];
          end
          if (hit_apwr[p]) begin
            rdata_next = pwr_reg[p];
          end
          if (hit_rpwr[p]) begin
            rdata_next = pwr_reg[p + 3];
          end
        end
      end
    end
  end

  // ==================== State registers ====================
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      run_reg       <= 1'b0;
      sum_sel_reg   <= 2'h0;
      act_byp_reg   <= 1'b0;
      react_byp_reg <= 1'b0;
      reactive_disable_reg   <= 1'b0;
      thr_reg       <= REG_RESET;
      n_os_reg      <= REG_RESET;
      s_os_reg      <= REG_RESET;
      gain_reg      <= '0;
      act_os_reg    <= '0;
      react_os_reg  <= '0;
      mask_reg      <= 1'b0;
      flag_reg      <= 1'b0;
      irq_reg       <= 1'b0;
      rdata_reg     <= REG_RESET;
      n_rms_reg     <= REG_RESET;
      s_rms_reg     <= REG_RESET;
      pwr_reg       <= '0;
      cmp_reg       <= 1'b0;
      post_reg      <= 1'b0;
      valid_reg     <= 1'b0;
      state_reg     <= ST_IDLE;
      bit_reg       <= 5'h0;
      root_reg      <= '0;
      val_reg       <= '0;
    end else begin
      run_reg       <= run_next;
      sum_sel_reg   <= sum_sel_next;
      act_byp_reg   <= act_byp_next;
      react_byp_reg <= react_byp_next;
      reactive_disable_reg   <= reactive_disable_next;
      thr_reg       <= thr_next;
      n_os_reg      <= n_os_next;
      s_os_reg      <= s_os_next;
      gain_reg      <= gain_next;
      act_os_reg    <= act_os_next;
      react_os_reg  <= react_os_next;
      mask_reg      <= mask_next;
      flag_reg      <= flag_next;
      irq_reg       <= irq_next;
      rdata_reg     <= rdata_next;
      n_rms_reg     <= n_rms_next;
      s_rms_reg     <= s_rms_next;
      pwr_reg       <= pwr_next;
      cmp_reg       <= cmp_next;
      post_reg      <= post_next;
      valid_reg     <= valid_next;
      state_reg     <= state_next;
      bit_reg       <= bit_next;
      root_reg      <= root_next;
      val_reg       <= val_next;
    end
  end

  assign rdata_out        = rdata_reg;
  assign result_valid_out = valid_reg;
  assign mismatch_irq_out = irq_reg;

endmodule : pps_meter_top

// *** verification/pps_meter_asserts.sv ***
// Port timing checker for the power and sum-rms block
`timescale 1ns/1ps
module pps_meter_asserts #(
  parameter int LPF_K = 14
) (
  input wire logic                       mclk_in,
  input wire logic                       reset_in,
  input wire logic [pps_pkg::ADDR_W-1:0] addr_in,
  input wire logic [pps_pkg::REG_W-1:0]  wdata_in,
  input wire logic                       wr_in,
  input wire logic                       rd_in,
  input wire logic [pps_pkg::REG_W-1:0]  rdata_out,
  input wire logic                       sample_valid_in,
  input wire logic                       result_valid_out,
  input wire logic                       mismatch_irq_out
);
  import pps_pkg::*;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  // ====================
  // Register bus
  property p_rd_idle; !$past(rd_in) |-> rdata_out == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_unmapped; rd_in && addr_in == 8'hFC |=> rdata_out == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // ====================
  // Result timing
  property p_rv_pulse; result_valid_out |=> !result_valid_out [*8]; endproperty
  a_rv_pulse: assert property (p_rv_pulse) else $error("result pulse too long");
  property p_rv_cause; result_valid_out |-> $past(sample_valid_in, 34); endproperty
  a_rv_cause: assert property (p_rv_cause) else $error("result without sample");
  // ====================
  // Mismatch flag and irq
  property p_irq_hold;
    !$past(wr_in) && !result_valid_out |-> $stable(mismatch_irq_out);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq moved without cause");
  property p_irq_rise;
    $rose(mismatch_irq_out) |-> result_valid_out || $past(wr_in);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without result");
  property p_clear;
    (wr_in && addr_in == OFS_STATUS_WORD_ZERO && wdata_in[ST_MISMATCH]) ##1 !result_valid_out
      |-> !mismatch_irq_out;
  endproperty
  a_clear: assert property (p_clear) else $error("irq kept after clear");
  property p_mask_off;
    wr_in && addr_in == OFS_MASK && !wdata_in[ST_MISMATCH] |=> !mismatch_irq_out;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq kept after mask off");
endmodule : pps_meter_asserts

bind pps_meter_top pps_meter_asserts #(.LPF_K(LPF_K)) i_chk (
  .mclk_in(mclk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .sample_valid_in(sample_valid_in),
  .result_valid_out(result_valid_out), .mismatch_irq_out(mismatch_irq_out));

// *** verification/pps_wave_src.sv ***
// Upstream waveform source: one sample beside a one-cycle strobe
`timescale 1ns/1ps
module pps_wave_src (
  input  wire logic                  mclk_in,
  input  wire logic                  reset_in,
  input  wire logic                  go_in,
  input  wire pps_pkg::pps_wave_type wave_in,
  output pps_pkg::pps_wave_type      waves_out,
  output logic                       sample_out
);
  import pps_pkg::*;
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      waves_out  <= '0;
      sample_out <= 1'b0;
    end else begin
      sample_out <= go_in;
      // Waves valid only beside the strobe
      waves_out  <= go_in ? wave_in : ~waves_out;
    end
  end
endmodule : pps_wave_src

// *** verification/tb_top.sv ***
// Self-checking bench for the power and sum-rms block
`timescale 1ns/1ps
module tb_top;
  import pps_pkg::*;
  localparam int LPF_K_TB = 2;
  logic              mclk_in  = 1'b0;
  logic              reset_in = 1'b1;
  logic [ADDR_W-1:0] addr     = '0;
  logic [REG_W-1:0]  wdata    = '0;
  logic              wr       = 1'b0;
  logic              rd       = 1'b0;
  logic              go       = 1'b0;
  logic              rd_d     = 1'b0;
  pps_wave_type      wave     = '0;
  pps_wave_type      waves;
  logic              sample;
  logic [REG_W-1:0]  rdata;
  logic              rvalid;
  logic              irq;
  logic [31:0]       seed     = 32'h2416EA08;
  logic [63:0]       exp_q[$];
  logic [63:0]       e;
  int                err_total = 0;
  int                n_checks  = 0;

  pps_wave_src i_src (.mclk_in(mclk_in), .reset_in(reset_in), .go_in(go), .wave_in(wave),
    .waves_out(waves), .sample_out(sample));
  pps_meter_top #(.LPF_K(LPF_K_TB)) i_dut (.mclk_in(mclk_in), .reset_in(reset_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .waves_in(waves), .sample_valid_in(sample), .result_valid_out(rvalid),
    .mismatch_irq_out(irq));

  initial begin
    forever #5 mclk_in = ~mclk_in;
  end

  // ====================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] pwr(input logic [WAVE_W-1:0] i, v, input longint g, os);
    longint p;
    p = (longint'($signed(i)) * longint'($signed(v))) >>> 24;
    return 32'(p + ((p * g) >>> 27) + os);
  endfunction : pwr
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    n_checks++;
    if (seen !== expv) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : check
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk_in);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] lo, hi);
    exp_q.push_back({lo, hi});
    @(posedge mclk_in);
    rd   <= 1'b1;
    addr <= a;
    @(posedge mclk_in);
    rd   <= 1'b0;
  endtask : rd_reg
  task automatic rd_eq(input logic [7:0] a, input logic [31:0] v);
    rd_reg(a, v, v);
  endtask : rd_eq
  task automatic send(input int n);
    repeat (n) begin
      @(posedge mclk_in);
      go <= 1'b1;
      @(posedge mclk_in);
      go <= 1'b0;
      repeat (38) @(posedge mclk_in);
    end
  endtask : send
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run

  // ====================
  // Read data scoreboard
  always @(posedge mclk_in) begin
    rd_d <= rd;
    if (rd_d) begin
      e = exp_q.pop_front();
      if (e[63:32] == e[31:0]) check(rdata, e[31:0]);
      else check({31'h0, rdata >= e[63:32] && rdata <= e[31:0]}, 32'h1);
    end
  end

  initial begin
    #300000;
    err_total++;
    complete_run();
  end

  // ====================
  // Main sequence
  initial begin
    longint      y;
    logic [31:0] last_a;
    int          s[4];
    s = '{6000, 38768, 26768, 6000};
    repeat (5) @(posedge mclk_in);
    reset_in <= 1'b0;
    for (int a = 0; a <= 8'h60; a += 4) rd_eq(8'(a), REG_RESET);
    rd_eq(8'hFC, 32'h0);
    wave.cur[0]  <= 28'h0010000;
    wave.volt[0] <= 28'h0010000;
    wr_reg(OFS_RUN, 32'h1);
    y = 0;
    for (int i = 0; i < 3; i++) begin
      y = y + (((64'sd1 <<< 32) - y) >>> LPF_K_TB);
      send(1);
      rd_eq(OFS_ACT_PWR, 32'(y >>> 24));
    end
    wr_reg(OFS_CONFIG_WORD_ZERO, 32'hC);
    for (int p = 0; p < 3; p++) begin
      wr_reg(OFS_PGAIN + 8'(4 * p), 32'((p - 1) * 33554432));
      wr_reg(OFS_ACT_OS + 8'(4 * p), 32'(16 * (p + 1)));
      wr_reg(OFS_REACT_OS + 8'(4 * p), 32'(-7 - p));
    end
    repeat (4) begin
      for (int p = 0; p < 3; p++) begin
        seed = lfsr(seed);
        wave.cur[p]  <= {{6{seed[7]}}, seed[7:0], 14'h0};
        wave.quad[p] <= {{6{seed[15]}}, seed[15:8], 14'h0};
        wave.volt[p] <= {{8{seed[23]}}, seed[23:16], 12'h0};
        wave.neu     <= {{8{seed[31]}}, seed[31:24], 12'h0};
      end
      send(1);
      for (int p = 0; p < 3; p++) begin
        rd_eq(OFS_ACT_PWR + 8'(4 * p),
              pwr(wave.cur[p], wave.volt[p], (p - 1) * 33554432, 16 * (p + 1)));
        rd_eq(OFS_REACT_PWR + 8'(4 * p),
              pwr(wave.quad[p], wave.volt[p], (p - 1) * 33554432, -7 - p));
      end
    end
    last_a = pwr(wave.cur[0], wave.volt[0], -33554432, 16);
    wr_reg(OFS_RUN, 32'h0);
    wr_reg(OFS_REACTIVE_DISABLE, 32'h1);
    wr_reg(OFS_RUN, 32'h1);
    send(1);
    rd_eq(OFS_REACT_PWR, 32'h0);
    wr_reg(OFS_RUN, 32'h0);
    wave.cur <= {28'd3000, 28'd2000, 28'd1000};
    wave.neu <= 28'd32768;
    send(1);
    rd_eq(OFS_ACT_PWR, last_a);
    wr_reg(OFS_RUN, 32'h1);
    wr_reg(OFS_N_RMS_OS, 32'h18000);
    wr_reg(OFS_SUM_THR, 32'd30000);
    for (int c = 0; c < 4; c++) begin
      wr_reg(OFS_CONFIG_WORD_ZERO, 32'hC | 32'(c));
      send(80);
      rd_reg(OFS_S_RMS, 32'(s[c] - 1), 32'(s[c]));
      if (c > 0) begin
        rd_eq(OFS_STATUS_WORD_ZERO, 32'((s[c] > 30000) != (s[c - 1] > 30000)));
        #1;
        check({31'h0, irq}, 32'((s[c] > 30000) != (s[c - 1] > 30000)));
      end
      wr_reg(OFS_STATUS_WORD_ZERO, 32'h1);
      wr_reg(OFS_MASK, 32'h1);
    end
    rd_reg(OFS_N_RMS, 32'd65535, 32'd65536);
    wr_reg(OFS_MASK, 32'h0);
    repeat (4) @(posedge mclk_in);
    complete_run();
  end
endmodule : tb_top
